// ---- pkg/spc_pkg.sv ----
// Package with constants, default image and load states of the sink profile block.
package spc_pkg;

  // Non-volatile image word addresses.
  localparam logic [2:0] NVM_ADDR_CFG = 3'h0;
  localparam logic [2:0] NVM_ADDR_CODE1 = 3'h1;
  localparam logic [2:0] NVM_ADDR_CODE2 = 3'h2;
  localparam logic [2:0] NVM_ADDR_CODE3 = 3'h3;
  localparam logic [2:0] NVM_ADDR_FINE = 3'h4;
  localparam logic [2:0] NVM_ADDR_VOLT2 = 3'h5;
  localparam logic [2:0] NVM_ADDR_VOLT3 = 3'h6;
  localparam logic [2:0] NVM_ADDR_LAST = 3'h6;

  // Field positions inside the configuration word.
  localparam int CFG_COUNT_LSB = 0;
  localparam int CFG_GATE_BIT = 2;

  // Default values held in the non-volatile image.
  localparam logic [1:0] DEF_PROFILE_COUNT = 2'h3;
  localparam logic DEF_GATE = 1'h0;
  localparam logic [3:0] DEF_CODE1 = 4'h5;
  localparam logic [3:0] DEF_CODE2 = 4'h5;
  localparam logic [3:0] DEF_CODE3 = 4'h3;
  localparam logic [9:0] DEF_FINE = 10'h0C8;
  localparam logic [9:0] DEF_VOLT2 = 10'h12C;
  localparam logic [9:0] DEF_VOLT3 = 10'h190;

  // Current decoding, all but LUT_COARSE_CODE in units of 10 mA.
  localparam logic [9:0] FINE_MIN = 10'h001;
  localparam logic [9:0] FINE_MAX = 10'h1F4;
  localparam logic [3:0] LUT_COARSE_CODE = 4'hC;
  localparam logic [9:0] LUT_FINE_BASE = 10'h032;
  localparam logic [9:0] LUT_FINE_STEP = 10'h019;
  localparam logic [9:0] LUT_COARSE_BASE = 10'h15E;
  localparam logic [9:0] LUT_COARSE_STEP = 10'h032;

  // Bus voltage figures in millivolts and margins in percent.
  localparam logic [15:0] PROFILE1_MV = 16'h1388;
  localparam logic [15:0] VOLT_UNIT_MV = 16'h0032;
  localparam logic [15:0] DETACH_MV = 16'h0CE4;
  localparam logic [6:0] LOW_MARGIN_PCT = 7'h14;
  localparam logic [6:0] HIGH1_MARGIN_PCT = 7'h0F;
  localparam logic [6:0] HIGH_MARGIN_PCT = 7'h0A;

  typedef enum logic [1:0] {
    SPC_LD_WAIT,
    SPC_LD_READ,
    SPC_LD_DONE
  } spc_load_e;

endpackage : spc_pkg

// ---- src/spc_nvm_rom.sv ----
// Embedded non-volatile default image with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module spc_nvm_rom
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic [2:0] addr,
  output logic [15:0] rdData_q
);

  always_ff @(posedge clock) begin
    case (addr)
      NVM_ADDR_CFG: begin
        rdData_q <= 16'(({15'h0, DEF_GATE} << CFG_GATE_BIT)
                   | ({14'h0, DEF_PROFILE_COUNT} << CFG_COUNT_LSB));
      end
      NVM_ADDR_CODE1: rdData_q <= {12'h000, DEF_CODE1};
      NVM_ADDR_CODE2: rdData_q <= {12'h000, DEF_CODE2};
      NVM_ADDR_CODE3: rdData_q <= {12'h000, DEF_CODE3};
      NVM_ADDR_FINE: rdData_q <= {6'h00, DEF_FINE};
      NVM_ADDR_VOLT2: rdData_q <= {6'h00, DEF_VOLT2};
      NVM_ADDR_VOLT3: rdData_q <= {6'h00, DEF_VOLT3};
      default: rdData_q <= 16'h0000;
    endcase
  end

endmodule : spc_nvm_rom
`default_nettype wire

// ---- src/spc_sink_profile.sv ----
// Sink profile configuration, default load and power path gating.
`timescale 1ns/10ps
`default_nettype none

module spc_sink_profile
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic coreRegulatorGood,
  input wire logic cfgWrite,
  input wire logic [2:0] cfgAddr,
  input wire logic [15:0] cfgData,
  input wire logic sourceAttached,
  input wire logic contractValid,
  input wire logic [1:0] contractProfile,
  input wire logic [2:0] sourceOffers,
  input wire logic deadBattery,
  input wire logic [15:0] vbusMv,
  output logic loadDone_q,
  output logic [1:0] profileCount_q,
  output logic highVoltageOnlyGate_q,
  output logic [9:0] profileCurrent1_q,
  output logic [9:0] profileCurrent2_q,
  output logic [9:0] profileCurrent3_q,
  output logic [15:0] profileVoltage2_q,
  output logic [15:0] profileVoltage3_q,
  output logic [1:0] requestProfile_q,
  output logic [9:0] requestCurrent_q,
  output logic [15:0] busLowLimit_q,
  output logic [15:0] busHighLimit_q,
  output logic vbusPresent_q,
  output logic vbusOutOfRange_q,
  output logic powerPathEnable_q
);

  function automatic logic [9:0] decodeCurrent(input logic [3:0] code,
                                               input logic [9:0] fine);
    logic [9:0] r;
    r = 10'h000;
    if (code == 4'h0) begin
      if (fine > FINE_MAX) begin
        r = FINE_MAX;
      end else if (fine < FINE_MIN) begin
        r = FINE_MIN;
      end else begin
        r = fine;
      end
    end else if (code < LUT_COARSE_CODE) begin
      r = 10'(LUT_FINE_BASE + LUT_FINE_STEP * 10'(code - 4'h1));
    end else begin
      r = 10'(LUT_COARSE_BASE
              + LUT_COARSE_STEP * 10'(code - LUT_COARSE_CODE));
    end
    return r;
  endfunction : decodeCurrent

  function automatic logic [15:0] marginMv(input logic [15:0] nom,
                                           input logic [6:0] pct);
    return 16'((32'(nom) * 32'(pct)) / 32'h64);
  endfunction : marginMv

  // Pin synchroniser for the regulator-good level.
  logic porSync1_q;
  logic porSync2_q;
  logic porSync3_q;
  logic porGood_q;

  always_ff @(posedge clock) begin
    porSync1_q <= coreRegulatorGood;
    porSync2_q <= porSync1_q;
    porSync3_q <= porSync2_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      porGood_q <= 1'b0;
    end else if (porSync2_q == porSync3_q) begin
      porGood_q <= porSync3_q;
    end
  end

  // Load sequencer.
  spc_load_e loadState_q;
  logic [2:0] romAddr_q;
  logic [2:0] capAddr_q;
  logic capValid_q;
  logic [15:0] romData;

  spc_nvm_rom nvm (
    .clock(clock),
    .addr(romAddr_q),
    .rdData_q(romData)
  );

  // The image is read again whenever the regulator drops, since a real
  // brown-out would have wiped the register contents as well.
  always_ff @(posedge clock) begin
    if (reset) begin
      loadState_q <= SPC_LD_WAIT;
      romAddr_q <= NVM_ADDR_CFG;
      capValid_q <= 1'b0;
      capAddr_q <= NVM_ADDR_CFG;
    end else if (!porGood_q) begin
      loadState_q <= SPC_LD_WAIT;
      romAddr_q <= NVM_ADDR_CFG;
      capValid_q <= 1'b0;
    end else begin
      capValid_q <= 1'b0;
      case (loadState_q)
        SPC_LD_WAIT: begin
          loadState_q <= SPC_LD_READ;
          romAddr_q <= NVM_ADDR_CFG;
        end
        SPC_LD_READ: begin
          capValid_q <= 1'b1;
          capAddr_q <= romAddr_q;
          if (romAddr_q == NVM_ADDR_LAST) begin
            loadState_q <= SPC_LD_DONE;
          end else begin
            romAddr_q <= 3'(romAddr_q + 3'h1);
          end
        end
        SPC_LD_DONE: loadState_q <= SPC_LD_DONE;
        default: loadState_q <= SPC_LD_WAIT;
      endcase
    end
  end

  // Done only after the last word has landed in the registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      loadDone_q <= 1'b0;
    end else begin
      loadDone_q <= (loadState_q == SPC_LD_DONE) && !capValid_q
                    && porGood_q;
    end
  end

  // Configuration registers: image words during load, host writes after.
  logic wrEn;
  logic [2:0] wrAddr;
  logic [15:0] wrData;
  logic [3:0] code1_q;
  logic [3:0] code2_q;
  logic [3:0] code3_q;
  logic [9:0] fine_q;
  logic [9:0] volt2_q;
  logic [9:0] volt3_q;

  always_comb begin
    wrEn = capValid_q || (cfgWrite && loadDone_q);
    wrAddr = capValid_q ? capAddr_q : cfgAddr;
    wrData = capValid_q ? romData : cfgData;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      profileCount_q <= DEF_PROFILE_COUNT;
      highVoltageOnlyGate_q <= DEF_GATE;
      code1_q <= DEF_CODE1;
      code2_q <= DEF_CODE2;
      code3_q <= DEF_CODE3;
      fine_q <= DEF_FINE;
      volt2_q <= DEF_VOLT2;
      volt3_q <= DEF_VOLT3;
    end else if (wrEn) begin
      case (wrAddr)
        NVM_ADDR_CFG: begin
          profileCount_q <= wrData[CFG_COUNT_LSB +: 2];
          highVoltageOnlyGate_q <= wrData[CFG_GATE_BIT];
        end
        NVM_ADDR_CODE1: code1_q <= wrData[3:0];
        NVM_ADDR_CODE2: code2_q <= wrData[3:0];
        NVM_ADDR_CODE3: code3_q <= wrData[3:0];
        NVM_ADDR_FINE: fine_q <= wrData[9:0];
        NVM_ADDR_VOLT2: volt2_q <= wrData[9:0];
        NVM_ADDR_VOLT3: volt3_q <= wrData[9:0];
        default: profileCount_q <= profileCount_q;
      endcase
    end
  end

  // Decoded profile table.
  always_ff @(posedge clock) begin
    if (reset) begin
      profileCurrent1_q <= 10'h000;
      profileCurrent2_q <= 10'h000;
      profileCurrent3_q <= 10'h000;
      profileVoltage2_q <= 16'h0000;
      profileVoltage3_q <= 16'h0000;
    end else begin
      profileCurrent1_q <= decodeCurrent(code1_q, fine_q);
      profileCurrent2_q <= decodeCurrent(code2_q, fine_q);
      profileCurrent3_q <= decodeCurrent(code3_q, fine_q);
      profileVoltage2_q <= 16'(32'(volt2_q) * 32'(VOLT_UNIT_MV));
      profileVoltage3_q <= 16'(32'(volt3_q) * 32'(VOLT_UNIT_MV));
    end
  end

  // Active profile count and the profile whose window is watched.
  logic [1:0] activeCount;
  logic [1:0] watched;
  logic [15:0] nominal;
  logic [15:0] lowLimit;
  logic [15:0] highLimit;
  logic inWindow;

  always_comb begin
    activeCount = (profileCount_q == 2'h0) ? 2'h1 : profileCount_q;
    watched = (contractValid && contractProfile != 2'h0
               && contractProfile <= activeCount) ? contractProfile : 2'h1;
    case (watched)
      2'h2: nominal = profileVoltage2_q;
      2'h3: nominal = profileVoltage3_q;
      default: nominal = PROFILE1_MV;
    endcase
    lowLimit = 16'(nominal - marginMv(nominal, LOW_MARGIN_PCT));
    if (watched == 2'h1) begin
      highLimit = 16'(nominal + marginMv(nominal, HIGH1_MARGIN_PCT));
    end else begin
      highLimit = 16'(nominal + marginMv(nominal, HIGH_MARGIN_PCT));
    end
    inWindow = (vbusMv >= lowLimit) && (vbusMv <= highLimit);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      busLowLimit_q <= 16'h0000;
      busHighLimit_q <= 16'h0000;
      vbusOutOfRange_q <= 1'b0;
    end else begin
      busLowLimit_q <= lowLimit;
      busHighLimit_q <= highLimit;
      vbusOutOfRange_q <= vbusPresent_q && !inWindow;
    end
  end

  // Attach inside the profile one window, detach only below the fixed floor.
  always_ff @(posedge clock) begin
    if (reset) begin
      vbusPresent_q <= 1'b0;
    end else if (vbusMv < DETACH_MV) begin
      vbusPresent_q <= 1'b0;
    end else if (inWindow && watched == 2'h1) begin
      vbusPresent_q <= 1'b1;
    end
  end

  // Request selection: profile three outranks two, two outranks one.
  always_ff @(posedge clock) begin
    if (reset) begin
      requestProfile_q <= 2'h1;
      requestCurrent_q <= 10'h000;
    end else if (sourceOffers[2] && activeCount == 2'h3) begin
      requestProfile_q <= 2'h3;
      requestCurrent_q <= profileCurrent3_q;
    end else if (sourceOffers[1] && activeCount >= 2'h2) begin
      requestProfile_q <= 2'h2;
      requestCurrent_q <= profileCurrent2_q;
    end else begin
      requestProfile_q <= 2'h1;
      requestCurrent_q <= profileCurrent1_q;
    end
  end

  // Power path. With the gate set the source stays attached on CC and a
  // later profile 2 or 3 contract within the active profile count still closes the path; nothing here tears down the link.
  logic highContract;

  always_comb begin
    highContract = contractValid && contractProfile >= 2'h2
                   && contractProfile <= activeCount;
  end

  always_ff @(posedge clock) begin
    if (reset || !loadDone_q) begin
      powerPathEnable_q <= 1'b0;
    end else if (!sourceAttached) begin
      powerPathEnable_q <= 1'b0;
    end else if (highVoltageOnlyGate_q) begin
      powerPathEnable_q <= highContract;
    end else if (deadBattery) begin
      powerPathEnable_q <= vbusPresent_q && inWindow;
    end else begin
      powerPathEnable_q <= 1'b1;
    end
  end

endmodule : spc_sink_profile
`default_nettype wire

// ---- verification/spc_sink_checker.sv ----
// Port checker for the sink profile block.
`timescale 1ns/10ps
`default_nettype none
module spc_sink_checker
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic coreRegulatorGood,
  input wire logic cfgWrite,
  input wire logic [2:0] cfgAddr,
  input wire logic [15:0] cfgData,
  input wire logic sourceAttached,
  input wire logic contractValid,
  input wire logic [1:0] contractProfile,
  input wire logic deadBattery,
  input wire logic loadDone_q,
  input wire logic [1:0] profileCount_q,
  input wire logic highVoltageOnlyGate_q,
  input wire logic [9:0] profileCurrent1_q,
  input wire logic [15:0] busLowLimit_q,
  input wire logic [15:0] busHighLimit_q,
  input wire logic vbusPresent_q,
  input wire logic powerPathEnable_q
);
  logic highContract;
  assign highContract = contractValid && contractProfile >= 2'h2;

  function automatic logic [9:0] amps(input logic [15:0] d);
    if (d[3:0] < LUT_COARSE_CODE) begin
      return 10'(LUT_FINE_BASE + LUT_FINE_STEP * 10'(d[3:0] - 4'h1));
    end
    return 10'(LUT_COARSE_BASE
               + LUT_COARSE_STEP * 10'(d[3:0] - LUT_COARSE_CODE));
  endfunction : amps

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  idle_off_a: assert property ((!loadDone_q || !sourceAttached) |=>
    !powerPathEnable_q) else $error("power path on while idle");
  gate_clear_a: assert property (loadDone_q && sourceAttached &&
    !deadBattery && !highVoltageOnlyGate_q |=> powerPathEnable_q)
    else $error("power path off while attached");
  gate_block_a: assert property (highVoltageOnlyGate_q &&
    !deadBattery && !highContract |=> !powerPathEnable_q)
    else $error("power path on without high contract");
  gate_open_a: assert property (loadDone_q && sourceAttached &&
    highVoltageOnlyGate_q && !deadBattery && highContract &&
    contractProfile <= profileCount_q |=> powerPathEnable_q)
    else $error("power path off after high contract");
  code_decode_a: assert property (cfgWrite && loadDone_q &&
    cfgAddr == NVM_ADDR_CODE1 && cfgData[3:0] != 4'h0 |->
    ##2 profileCurrent1_q == amps($past(cfgData, 2)))
    else $error("current code decoded wrongly");
  limit_ratio_a: assert property (loadDone_q && $stable(busLowLimit_q)
    |-> (32'(busLowLimit_q) * 11 == 32'(busHighLimit_q) * 8) ||
    (32'(busLowLimit_q) * 23 == 32'(busHighLimit_q) * 16))
    else $error("bus window limits out of ratio");
  load_time_a: assert property ($fell(reset) && coreRegulatorGood |->
    !loadDone_q [*4] ##[1:40] loadDone_q) else $error("load time wrong");
  dead_hold_a: assert property (deadBattery && !vbusPresent_q |=>
    !powerPathEnable_q) else $error("dead battery path on without bus");

  cover property (highVoltageOnlyGate_q && powerPathEnable_q);
  cover property ($rose(loadDone_q));
  cover property (deadBattery && powerPathEnable_q);
endmodule : spc_sink_checker
bind spc_sink_profile spc_sink_checker chk_u (
  .clock(clock), .reset(reset), .coreRegulatorGood(coreRegulatorGood),
  .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData),
  .sourceAttached(sourceAttached), .contractValid(contractValid),
  .contractProfile(contractProfile), .deadBattery(deadBattery),
  .loadDone_q(loadDone_q), .profileCount_q(profileCount_q),
  .highVoltageOnlyGate_q(highVoltageOnlyGate_q),
  .profileCurrent1_q(profileCurrent1_q), .busLowLimit_q(busLowLimit_q),
  .busHighLimit_q(busHighLimit_q), .vbusPresent_q(vbusPresent_q),
  .powerPathEnable_q(powerPathEnable_q)
);
`default_nettype wire

// ---- verification/spc_source_model.sv ----
// Behavioural power source that faces the sink profile block.
`timescale 1ns/10ps
`default_nettype none
module spc_source_model
  import spc_pkg::*;
#(
  parameter int CONTRACT_DELAY = 3,
  parameter logic [15:0] PROFILE2_MV = 16'h3A98,
  parameter logic [15:0] PROFILE3_MV = 16'h4E20
) (
  input wire logic clock,
  input wire logic plugIn,
  input wire logic [1:0] wantProfile,
  input wire logic [2:0] offers,
  output logic sourceAttached,
  output logic contractValid,
  output logic [1:0] contractProfile,
  output logic [2:0] sourceOffers,
  output logic [15:0] vbusMv
);
  int waitCount = 0;
  always_ff @(posedge clock) begin
    sourceAttached <= plugIn;
    sourceOffers <= offers;
    if (!plugIn) begin
      // The bus is discharged to ground once the plug is gone.
      contractValid <= 1'b0;
      contractProfile <= 2'h0;
      vbusMv <= 16'h0000;
      waitCount <= 0;
    end else if (wantProfile != contractProfile) begin
      // Renegotiation falls back to 5 V until the new contract holds.
      contractValid <= 1'b0;
      vbusMv <= PROFILE1_MV;
      waitCount <= waitCount + 1;
      if (waitCount == CONTRACT_DELAY) begin
        contractProfile <= wantProfile;
        waitCount <= 0;
      end
    end else begin
      contractValid <= wantProfile != 2'h0;
      vbusMv <= wantProfile == 2'h3 ? PROFILE3_MV :
        wantProfile == 2'h2 ? PROFILE2_MV : PROFILE1_MV;
    end
  end
endmodule : spc_source_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the sink profile block.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import spc_pkg::*;
;
  logic clock = 1'b0, reset = 1'b1, coreRegulatorGood = 1'b0;
  logic cfgWrite = 1'b0, plugIn = 1'b0, deadBattery = 1'b0;
  logic [2:0] cfgAddr = 3'h0, offers = 3'h7;
  logic [15:0] cfgData = 16'h0000;
  logic [1:0] wantProfile = 2'h0;
  logic loadDone_q, highVoltageOnlyGate_q, vbusPresent_q, vbusOutOfRange_q;
  logic powerPathEnable_q, sourceAttached, contractValid;
  logic [1:0] profileCount_q, requestProfile_q, contractProfile;
  logic [2:0] sourceOffers;
  logic [9:0] profileCurrent1_q, profileCurrent2_q, profileCurrent3_q;
  logic [9:0] requestCurrent_q;
  logic [15:0] profileVoltage2_q, profileVoltage3_q, vbusMv;
  logic [15:0] busLowLimit_q, busHighLimit_q;
  int miscompares = 0, compares = 0;

  always #12.5 clock = ~clock;
  spc_sink_profile dut_u (
    .clock(clock), .reset(reset), .coreRegulatorGood(coreRegulatorGood),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData),
    .sourceAttached(sourceAttached), .contractValid(contractValid),
    .contractProfile(contractProfile), .sourceOffers(sourceOffers),
    .deadBattery(deadBattery), .vbusMv(vbusMv), .loadDone_q(loadDone_q),
    .profileCount_q(profileCount_q),
    .highVoltageOnlyGate_q(highVoltageOnlyGate_q),
    .profileCurrent1_q(profileCurrent1_q),
    .profileCurrent2_q(profileCurrent2_q),
    .profileCurrent3_q(profileCurrent3_q),
    .profileVoltage2_q(profileVoltage2_q),
    .profileVoltage3_q(profileVoltage3_q),
    .requestProfile_q(requestProfile_q), .requestCurrent_q(requestCurrent_q),
    .busLowLimit_q(busLowLimit_q), .busHighLimit_q(busHighLimit_q),
    .vbusPresent_q(vbusPresent_q), .vbusOutOfRange_q(vbusOutOfRange_q),
    .powerPathEnable_q(powerPathEnable_q)
  );
  spc_source_model src_u (
    .clock(clock), .plugIn(plugIn), .wantProfile(wantProfile),
    .offers(offers), .sourceAttached(sourceAttached),
    .contractValid(contractValid), .contractProfile(contractProfile),
    .sourceOffers(sourceOffers), .vbusMv(vbusMv)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgData = d;
    step(1);
    cfgWrite = 1'b0;
    step(1);
  endtask : wr

  task automatic wait_load();
    int n;
    n = 0;
    while (loadDone_q !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    check(loadDone_q, 1'b1);
    step(1);
  endtask : wait_load

  task automatic t_load();
    step(30);
    check(loadDone_q, 1'b0);
    coreRegulatorGood = 1'b1;
    wait_load();
    check(profileCount_q, 2'h3);
    check(highVoltageOnlyGate_q, 1'b0);
    check(profileCurrent1_q, 10'h096);
    check(profileCurrent2_q, 10'h096);
    check(profileCurrent3_q, 10'h064);
    check(profileVoltage2_q, 16'h3A98);
    check(profileVoltage3_q, 16'h4E20);
    $display("test load finished");
  endtask : t_load

  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      wr(NVM_ADDR_CODE1, 16'(c));
      check(profileCurrent1_q, c == 0 ? 10'h0C8 : c < 12 ?
        10'(25 * (c + 1)) : 10'(350 + 50 * (c - 12)));
    end
    wr(NVM_ADDR_CODE1, 16'h0000);
    wr(NVM_ADDR_FINE, 16'h0258);
    check(profileCurrent1_q, 10'h1F4);
    wr(NVM_ADDR_FINE, 16'h0001);
    check(profileCurrent1_q, 10'h001);
    wr(NVM_ADDR_FINE, 16'h00C8);
    wr(NVM_ADDR_CODE1, 16'h0005);
    $display("test codes finished");
  endtask : t_codes

  task automatic t_gate();
    wr(NVM_ADDR_CFG, 16'h0007);
    plugIn = 1'b1;
    step(10);
    check(powerPathEnable_q, 1'b0);
    check(vbusPresent_q, 1'b1);
    check(busLowLimit_q, 16'h0FA0);
    check(busHighLimit_q, 16'h1676);
    wantProfile = 2'h1;
    step(10);
    check(powerPathEnable_q, 1'b0);
    wantProfile = 2'h3;
    step(10);
    check(powerPathEnable_q, 1'b1);
    check(busLowLimit_q, 16'h3E80);
    check(busHighLimit_q, 16'h55F0);
    check(vbusOutOfRange_q, 1'b0);
    wr(NVM_ADDR_CFG, 16'h0006);
    step(1);
    check(vbusOutOfRange_q, 1'b1);
    check(powerPathEnable_q, 1'b0);
    plugIn = 1'b0;
    wantProfile = 2'h0;
    step(10);
    check(powerPathEnable_q, 1'b0);
    check(vbusPresent_q, 1'b0);
    $display("test gate finished");
  endtask : t_gate

  task automatic t_count();
    wr(NVM_ADDR_CFG, 16'h0003);
    plugIn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(NVM_ADDR_CFG, 16'(k));
      step(4);
      check(requestProfile_q, k < 2 ? 2'h1 : 2'(k));
    end
    offers = 3'h3;
    step(4);
    check(requestProfile_q, 2'h2);
    check(requestCurrent_q, 10'h096);
    check(powerPathEnable_q, 1'b1);
    plugIn = 1'b0;
    offers = 3'h7;
    step(10);
    $display("test count finished");
  endtask : t_count

  task automatic t_dead();
    deadBattery = 1'b1;
    plugIn = 1'b1;
    step(10);
    check(powerPathEnable_q, 1'b1);
    plugIn = 1'b0;
    step(10);
    check(powerPathEnable_q, 1'b0);
    deadBattery = 1'b0;
    $display("test dead battery finished");
  endtask : t_dead

  task automatic t_reset();
    wr(NVM_ADDR_CODE3, 16'h000F);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
    check(loadDone_q, 1'b0);
    wr(NVM_ADDR_CODE3, 16'h0001);
    wait_load();
    check(profileCurrent3_q, 10'h064);
    $display("test reset finished");
  endtask : t_reset

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    step(20);
    reset = 1'b0;
    t_load();
    t_codes();
    t_gate();
    t_count();
    t_dead();
    t_reset();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
